//--- core/csl_config_shadow_loader.sv
// Purpose: Reload configuration shadow registers from flash after each reset.
// Assumes: Flash read port and table-read port run on ref_clk.
// Notes: Shadows read all ones until the load completes.
//
// Overview of operation
// - Programmed bit reads 0, unprogrammed reads 1
// - Read-only shadows start at 0xF80000
// - Reached only by table reads, config space
// - Shadows volatile; reloaded after every power-up
// - Fetch the two top flash words
// - Unpack word bits into separate shadows
// - Reload on every kind of reset
// - Upper byte of each word ignored
// - Erased last page loads zeros, protecting code
// - Oscillator select shadow field layout
// - Oscillator config shadow field layout
// - Watchdog shadow field layout
// - Reset and pin shadow field layout
// - Debug shadow: channel select, reserved bits
// - Unimplemented shadow bits read as 1
// - Word addresses depend on flash size
// - Zero protect bit enables that protection
`timescale 1ns/10ps
`default_nettype none
module csl_config_shadow_loader #(
	parameter bit LARGE_FLASH = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Flash read port
	output logic flash_rd_req,
	output logic [23:0] flash_rd_addr,
	input wire logic flash_rd_valid,
	input wire logic [23:0] flash_rd_data,
	// Table-read port
	input wire logic tbl_rd_en,
	input wire logic tbl_wr_en,
	input wire logic [23:0] tbl_addr,
	input wire logic [7:0] tbl_wr_data,
	output logic tbl_rd_valid,
	output logic [7:0] tbl_rd_data,
	// Load status
	output logic cfg_loaded,
	// Configuration consumers
	output logic code_protect_en,
	output logic write_protect_en,
	output logic two_speed_startup,
	output logic pwm_key_lock,
	output logic [1:0] watchdog_window_sel,
	output logic [2:0] initial_osc_sel,
	output logic [1:0] clock_switch_monitor_mode,
	output logic pin_remap_once,
	output logic osc2_pin_function,
	output logic [1:0] primary_osc_mode,
	output logic watchdog_force_enable,
	output logic watchdog_window_disable,
	output logic pll_lock_wait,
	output logic watchdog_prescale_sel,
	output logic [3:0] watchdog_postscale_sel,
	output logic pwm_pin_owner,
	output logic high_side_polarity,
	output logic low_side_polarity,
	output logic alt_i2c_pins,
	output logic [1:0] debug_channel_sel
);
	csl_pkg::csl_state_t state_ff, nxt_state;
	logic [15:0] word_a_ff, word_b_ff;
	logic [7:0] segment_protect_shadow_ff, osc_select_shadow_ff, osc_config_shadow_ff;
	logic [7:0] watchdog_config_shadow_ff, reset_pins_shadow_ff, debug_config_shadow_ff;
	logic loaded_ff, rd_valid_ff;
	logic [7:0] rd_data_ff;

	// Flash word addresses
	wire [23:0] word_a_addr = LARGE_FLASH ? csl_pkg::LARGE_WORD_A_ADDR
		: csl_pkg::SMALL_WORD_A_ADDR;
	wire [23:0] word_b_addr = LARGE_FLASH ? csl_pkg::LARGE_WORD_B_ADDR
		: csl_pkg::SMALL_WORD_B_ADDR;

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			csl_pkg::ST_REQ_B: nxt_state = csl_pkg::ST_WAIT_B;
			csl_pkg::ST_WAIT_B: if (flash_rd_valid) nxt_state = csl_pkg::ST_REQ_A;
			csl_pkg::ST_REQ_A: nxt_state = csl_pkg::ST_WAIT_A;
			csl_pkg::ST_WAIT_A: if (flash_rd_valid) nxt_state = csl_pkg::ST_COMMIT;
			csl_pkg::ST_COMMIT: nxt_state = csl_pkg::ST_DONE;
			csl_pkg::ST_DONE: nxt_state = csl_pkg::ST_DONE;
		endcase
	end

	// Both words fetched after any reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_ff <= csl_pkg::ST_REQ_B;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Held low in reset so the flash sees one pulse per word
	assign flash_rd_req = !sys_rst && ((state_ff == csl_pkg::ST_REQ_B)
		|| (state_ff == csl_pkg::ST_REQ_A));
	assign flash_rd_addr = (state_ff == csl_pkg::ST_REQ_A) ? word_a_addr : word_b_addr;

	// Staging; upper byte of each word is dropped
	wire take_b = (state_ff == csl_pkg::ST_WAIT_B) && flash_rd_valid;
	wire take_a = (state_ff == csl_pkg::ST_WAIT_A) && flash_rd_valid;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			word_a_ff <= csl_pkg::STAGE_RESET;
			word_b_ff <= csl_pkg::STAGE_RESET;
		end else begin
			if (take_a) word_a_ff <= flash_rd_data[15:0];
			if (take_b) word_b_ff <= flash_rd_data[15:0];
		end
	end

	// Unpacked shadow images; unimplemented bits held at 1
	wire [7:0] img_segment = {6'h3F, word_a_ff[csl_pkg::WA_CODE_PROT],
		word_a_ff[csl_pkg::WA_WRITE_PROT]};
	wire [7:0] img_osc_select = {word_b_ff[csl_pkg::WB_TWO_SPEED],
		word_b_ff[csl_pkg::WB_PWM_LOCK], 1'b1,
		word_b_ff[csl_pkg::WB_WDT_WIN +: 2],
		word_b_ff[csl_pkg::WB_INIT_OSC +: 3]};
	wire [7:0] img_osc_config = {word_b_ff[csl_pkg::WB_CLK_SW +: 2],
		word_b_ff[csl_pkg::WB_REMAP_ONCE], 2'b11,
		word_b_ff[csl_pkg::WB_OSC2_FN],
		word_b_ff[csl_pkg::WB_PRI_OSC +: 2]};
	wire [7:0] img_watchdog = word_a_ff[csl_pkg::WA_WDT_LO +: 8];
	wire [7:0] img_reset_pins = {word_b_ff[csl_pkg::WB_PWM_OWNER],
		word_a_ff[csl_pkg::WA_HIGH_POL], word_b_ff[csl_pkg::WB_LOW_POL],
		word_b_ff[csl_pkg::WB_ALT_I2C], 4'hF};
	// Reserved bits carried as programmed, so the tools see their value
	wire [7:0] img_debug = {word_a_ff[csl_pkg::WA_TOOL_RSV], 1'b1,
		word_a_ff[csl_pkg::WA_RSV_HI], word_a_ff[csl_pkg::WA_RSV_LO], 2'b11,
		word_a_ff[csl_pkg::WA_DBG_CH +: 2]};

	// Shadows change only on reset and at commit, never by a write
	wire commit = (state_ff == csl_pkg::ST_COMMIT);
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			segment_protect_shadow_ff <= csl_pkg::SHADOW_RESET;
			osc_select_shadow_ff <= csl_pkg::SHADOW_RESET;
			osc_config_shadow_ff <= csl_pkg::SHADOW_RESET;
			watchdog_config_shadow_ff <= csl_pkg::SHADOW_RESET;
			reset_pins_shadow_ff <= csl_pkg::SHADOW_RESET;
			debug_config_shadow_ff <= csl_pkg::SHADOW_RESET;
			loaded_ff <= 1'b0;
		end else if (commit) begin
			segment_protect_shadow_ff <= img_segment;
			osc_select_shadow_ff <= img_osc_select;
			osc_config_shadow_ff <= img_osc_config;
			watchdog_config_shadow_ff <= img_watchdog;
			reset_pins_shadow_ff <= img_reset_pins;
			debug_config_shadow_ff <= img_debug;
			loaded_ff <= 1'b1;
		end
	end
	assign cfg_loaded = loaded_ff;

	// Table-read decode
	wire in_cfg_space = tbl_addr >= csl_pkg::CFG_SPACE_BASE;
	wire hit_seg = tbl_addr == csl_pkg::OFS_SEGMENT_PROTECT;
	wire hit_oss = tbl_addr == csl_pkg::OFS_OSC_SELECT;
	wire hit_osc = tbl_addr == csl_pkg::OFS_OSC_CONFIG;
	wire hit_wdt = tbl_addr == csl_pkg::OFS_WATCHDOG_CONFIG;
	wire hit_rst = tbl_addr == csl_pkg::OFS_RESET_PINS;
	wire hit_dbg = tbl_addr == csl_pkg::OFS_DEBUG_CONFIG;
	wire [7:0] rd_mux = hit_seg ? segment_protect_shadow_ff
		: hit_oss ? osc_select_shadow_ff
		: hit_osc ? osc_config_shadow_ff
		: hit_wdt ? watchdog_config_shadow_ff
		: hit_rst ? reset_pins_shadow_ff
		: hit_dbg ? debug_config_shadow_ff
		: csl_pkg::UNMAPPED_READ;
	// Write attempts have no path into the shadows
	wire wr_dropped = tbl_wr_en && in_cfg_space && (tbl_wr_data != 8'h00 || 1'b1);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_valid_ff <= 1'b0;
			rd_data_ff <= csl_pkg::UNMAPPED_READ;
		end else begin
			rd_valid_ff <= tbl_rd_en && in_cfg_space;
			if (tbl_rd_en && in_cfg_space) rd_data_ff <= rd_mux;
		end
	end
	assign tbl_rd_valid = rd_valid_ff;
	assign tbl_rd_data = rd_data_ff;

	// Consumer fields; erased page gives zeros and so protection
	assign code_protect_en = ~segment_protect_shadow_ff[1];
	assign write_protect_en = ~segment_protect_shadow_ff[0];
	assign two_speed_startup = osc_select_shadow_ff[7];
	assign pwm_key_lock = osc_select_shadow_ff[6];
	assign watchdog_window_sel = osc_select_shadow_ff[4:3];
	assign initial_osc_sel = osc_select_shadow_ff[2:0];
	assign clock_switch_monitor_mode = osc_config_shadow_ff[7:6];
	assign pin_remap_once = osc_config_shadow_ff[5];
	assign osc2_pin_function = osc_config_shadow_ff[2];
	assign primary_osc_mode = osc_config_shadow_ff[1:0];
	assign watchdog_force_enable = watchdog_config_shadow_ff[7];
	assign watchdog_window_disable = watchdog_config_shadow_ff[6];
	assign pll_lock_wait = watchdog_config_shadow_ff[5];
	assign watchdog_prescale_sel = watchdog_config_shadow_ff[4];
	assign watchdog_postscale_sel = watchdog_config_shadow_ff[3:0];
	assign pwm_pin_owner = reset_pins_shadow_ff[7];
	assign high_side_polarity = reset_pins_shadow_ff[6];
	assign low_side_polarity = reset_pins_shadow_ff[5];
	assign alt_i2c_pins = reset_pins_shadow_ff[4];
	assign debug_channel_sel = debug_config_shadow_ff[1:0];

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_reset_all_ones: assert property (
		$past(sys_rst) && !commit |-> !cfg_loaded
		&& segment_protect_shadow_ff == 8'hFF && debug_config_shadow_ff == 8'hFF)
		else $error("shadows not all ones after reset");
	a_fetch_order: assert property (
		$past(sys_rst) && state_ff == csl_pkg::ST_REQ_B |-> flash_rd_req
		&& flash_rd_addr == word_b_addr)
		else $error("first fetch is not word B");
	a_fetch_addr: assert property (
		flash_rd_req |-> flash_rd_addr == word_a_addr || flash_rd_addr == word_b_addr)
		else $error("fetch outside configuration words");
	a_commit_map: assert property (
		commit |=> cfg_loaded && segment_protect_shadow_ff == {6'h3F, $past(word_a_ff[13:12])}
		&& watchdog_config_shadow_ff == $past(word_a_ff[7:0])
		&& initial_osc_sel == $past(word_b_ff[10:8]))
		else $error("shadow unpack mismatch");
	a_upper_ignored: assert property (
		take_a |=> word_a_ff == $past(flash_rd_data[15:0]))
		else $error("word A staging wrong");
	a_unimpl_ones: assert property (
		segment_protect_shadow_ff[7:2] == 6'h3F && osc_select_shadow_ff[5]
		&& osc_config_shadow_ff[4:3] == 2'b11 && reset_pins_shadow_ff[3:0] == 4'hF
		&& debug_config_shadow_ff[6] && debug_config_shadow_ff[3:2] == 2'b11)
		else $error("unimplemented bit reads 0");
	a_write_ignored: assert property (
		wr_dropped && !commit |=> $stable(osc_config_shadow_ff)
		&& $stable(reset_pins_shadow_ff) && $stable(segment_protect_shadow_ff))
		else $error("write changed a shadow");
	a_read_answer: assert property (
		tbl_rd_en && hit_seg |=> tbl_rd_valid
		&& tbl_rd_data == $past(segment_protect_shadow_ff))
		else $error("segment shadow read wrong");
	a_outside_space: assert property (
		tbl_rd_en && !in_cfg_space |=> !tbl_rd_valid)
		else $error("read answered outside config space");
	a_protect_level: assert property (
		cfg_loaded && word_a_ff[13] == 1'b0 |-> code_protect_en)
		else $error("code protect not enabled by 0");
	a_protect_off: assert property (
		cfg_loaded && word_a_ff[13] |-> !code_protect_en)
		else $error("code protect on while bit is 1");
	a_write_prot_level: assert property (
		cfg_loaded && word_a_ff[12] == 1'b0 |-> write_protect_en)
		else $error("write protect not enabled by 0");
	a_erased_protects: assert property (
		commit && word_a_ff[13:12] == 2'b00 |=> code_protect_en && write_protect_en)
		else $error("erased words left memory unprotected");
	a_raw_polarity: assert property (
		commit && !word_b_ff[15] && word_b_ff[14] |=> !two_speed_startup && pwm_key_lock)
		else $error("programmed bit not read as 0");
	a_outputs_reset: assert property (
		!cfg_loaded |-> !code_protect_en && !write_protect_en)
		else $error("protection active before load");

	// Field layouts checked against the staged words
	a_osc_sel_map: assert property (
		commit |=> osc_select_shadow_ff == {$past(word_b_ff[15:14]), 1'b1,
		$past(word_b_ff[12:8])})
		else $error("oscillator select layout wrong");
	a_osc_cfg_map: assert property (
		commit |=> osc_config_shadow_ff == {$past(word_b_ff[7:6]), $past(word_b_ff[4]),
		2'b11, $past(word_b_ff[5]), $past(word_b_ff[1:0])})
		else $error("oscillator config layout wrong");
	a_wdt_fields: assert property (
		commit |=> {watchdog_force_enable, watchdog_window_disable, pll_lock_wait,
		watchdog_prescale_sel, watchdog_postscale_sel} == $past(word_a_ff[7:0]))
		else $error("watchdog fields wrong");
	a_pin_map: assert property (
		commit |=> {pwm_pin_owner, high_side_polarity, low_side_polarity, alt_i2c_pins}
		== {$past(word_b_ff[13]), $past(word_a_ff[10]), $past(word_b_ff[3:2])}
		&& reset_pins_shadow_ff[3:0] == 4'hF)
		else $error("reset and pin fields wrong");
	a_debug_map: assert property (
		commit |=> debug_config_shadow_ff == {$past(word_a_ff[11]), 1'b1,
		$past(word_a_ff[15:14]), 2'b11, $past(word_a_ff[9:8])})
		else $error("debug shadow layout wrong");

	// Load sequencing
	a_stage_b: assert property (
		take_b |=> word_b_ff == $past(flash_rd_data[15:0]))
		else $error("word B staging wrong");
	a_second_fetch: assert property (
		take_b |=> flash_rd_req && flash_rd_addr == word_a_addr)
		else $error("word A not fetched after word B");
	a_req_pulse: assert property (
		flash_rd_req |=> !flash_rd_req)
		else $error("flash request longer than one cycle");
	a_wait_holds: assert property (
		state_ff == csl_pkg::ST_WAIT_B && !flash_rd_valid |=> state_ff == csl_pkg::ST_WAIT_B
		&& !flash_rd_req)
		else $error("left word B wait without an answer");
	a_addr_variant: assert property (
		flash_rd_req |-> (LARGE_FLASH ? flash_rd_addr[23:2] == csl_pkg::LARGE_WORD_B_ADDR[23:2]
		: flash_rd_addr[23:2] == csl_pkg::SMALL_WORD_B_ADDR[23:2]))
		else $error("fetch address wrong for flash size");
	a_load_follows: assert property (
		take_a |-> ##2 cfg_loaded)
		else $error("load not committed after last word");
	a_loaded_sticky: assert property (
		cfg_loaded |=> cfg_loaded)
		else $error("load status dropped without reset");
	a_shadow_hold: assert property (
		!commit |=> $stable(segment_protect_shadow_ff) && $stable(osc_select_shadow_ff)
		&& $stable(osc_config_shadow_ff) && $stable(watchdog_config_shadow_ff)
		&& $stable(reset_pins_shadow_ff) && $stable(debug_config_shadow_ff))
		else $error("shadow changed outside commit");

	// Table-read answers
	a_read_pulse: assert property (
		tbl_rd_valid |-> $past(tbl_rd_en) && $past(in_cfg_space))
		else $error("read answer without accepted request");
	a_unmapped_ff: assert property (
		tbl_rd_en && in_cfg_space && !(hit_seg || hit_oss || hit_osc || hit_wdt || hit_rst
		|| hit_dbg) |=> tbl_rd_valid && tbl_rd_data == csl_pkg::UNMAPPED_READ)
		else $error("unmapped read not all ones");
	a_first_read_ff: assert property (
		!cfg_loaded && tbl_rd_en && in_cfg_space |=> tbl_rd_data == csl_pkg::SHADOW_RESET)
		else $error("read before load not all ones");
	a_data_held: assert property (
		!$past(sys_rst) && !$past(tbl_rd_en) |-> $stable(tbl_rd_data))
		else $error("read data changed without a read");

	c_load_done: cover property ($rose(cfg_loaded));
	c_dbg_read: cover property (tbl_rd_en && hit_dbg ##1 tbl_rd_valid);
	c_wr_try: cover property (cfg_loaded && wr_dropped);
	c_protected: cover property (cfg_loaded && code_protect_en);
	c_slow_flash: cover property (state_ff == csl_pkg::ST_WAIT_A && !flash_rd_valid ##1 take_a);
endmodule
`default_nettype wire

//--- core/csl_pkg.sv
// Purpose: Constants for the configuration shadow loader.
// Assumes: Program memory addresses are 24-bit, flash words 24-bit.
// Notes: Shadow registers are 8 bits wide and read-only.
package csl_pkg;
	localparam int ADDR_W = 24;
	localparam int FWORD_W = 24;
	localparam int REG_W = 8;
	// Shadow register byte addresses in configuration space
	localparam logic [23:0] CFG_SPACE_BASE = 24'h800000;
	localparam logic [23:0] SHADOW_BASE = 24'hF80000;
	localparam logic [23:0] OFS_SEGMENT_PROTECT = 24'hF80004;
	localparam logic [23:0] OFS_OSC_SELECT = 24'hF80006;
	localparam logic [23:0] OFS_OSC_CONFIG = 24'hF80008;
	localparam logic [23:0] OFS_WATCHDOG_CONFIG = 24'hF8000A;
	localparam logic [23:0] OFS_RESET_PINS = 24'hF8000C;
	localparam logic [23:0] OFS_DEBUG_CONFIG = 24'hF8000E;
	// Flash configuration word locations, per flash size
	localparam logic [23:0] SMALL_WORD_B_ADDR = 24'h002BFC;
	localparam logic [23:0] SMALL_WORD_A_ADDR = 24'h002BFE;
	localparam logic [23:0] LARGE_WORD_B_ADDR = 24'h0057FC;
	localparam logic [23:0] LARGE_WORD_A_ADDR = 24'h0057FE;
	// Values before a load and for unmapped reads
	localparam logic [7:0] SHADOW_RESET = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ = 8'hFF;
	localparam logic [15:0] STAGE_RESET = 16'hFFFF;
	// Word A field positions
	localparam int WA_RSV_HI = 15;
	localparam int WA_RSV_LO = 14;
	localparam int WA_CODE_PROT = 13;
	localparam int WA_WRITE_PROT = 12;
	localparam int WA_TOOL_RSV = 11;
	localparam int WA_HIGH_POL = 10;
	localparam int WA_DBG_CH = 8;
	localparam int WA_WDT_LO = 0;
	// Word B field positions
	localparam int WB_TWO_SPEED = 15;
	localparam int WB_PWM_LOCK = 14;
	localparam int WB_PWM_OWNER = 13;
	localparam int WB_WDT_WIN = 11;
	localparam int WB_INIT_OSC = 8;
	localparam int WB_CLK_SW = 6;
	localparam int WB_OSC2_FN = 5;
	localparam int WB_REMAP_ONCE = 4;
	localparam int WB_LOW_POL = 3;
	localparam int WB_ALT_I2C = 2;
	localparam int WB_PRI_OSC = 0;
	typedef enum logic [2:0] {
		ST_REQ_B, ST_WAIT_B, ST_REQ_A, ST_WAIT_A, ST_COMMIT, ST_DONE
	} csl_state_t;
endpackage

//--- tb/config_shadow_loader_tb.sv
// Purpose: Self-checking bench for the configuration shadow loader.
// Assumes: Large-flash variant; stimulus changes on the falling edge.
// Notes: Each load is started by a full reset, so every load_check test after the first is a reload.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module config_shadow_loader_tb;
	logic ref_clk = 1'b0, sys_rst = 1'b1;
	logic flash_rd_req, flash_rd_valid, tbl_rd_valid, cfg_loaded;
	logic [23:0] flash_rd_addr, flash_rd_data, word_a = 24'hFFFFFF, word_b = 24'hFFFFFF;
	logic tbl_rd_en = 1'b0, tbl_wr_en = 1'b0;
	logic [23:0] tbl_addr = 24'h000000;
	logic [7:0] tbl_wr_data = 8'h00, tbl_rd_data;
	logic [3:0] lat = 4'h1;
	logic code_protect_en, write_protect_en, two_speed_startup, pwm_key_lock, pin_remap_once;
	logic osc2_pin_function, watchdog_force_enable, watchdog_window_disable, pll_lock_wait;
	logic watchdog_prescale_sel, pwm_pin_owner, high_side_polarity, low_side_polarity;
	logic alt_i2c_pins;
	logic [1:0] watchdog_window_sel, clock_switch_monitor_mode, primary_osc_mode;
	logic [1:0] debug_channel_sel;
	logic [2:0] initial_osc_sel;
	logic [3:0] watchdog_postscale_sel;
	logic [23:0] addrs[$];
	int failures = 0, checked = 0;
	initial forever #50 ref_clk = ~ref_clk;
	csl_config_shadow_loader #(.LARGE_FLASH(1'b1)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
		.flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
		.tbl_rd_en(tbl_rd_en), .tbl_wr_en(tbl_wr_en), .tbl_addr(tbl_addr),
		.tbl_wr_data(tbl_wr_data), .tbl_rd_valid(tbl_rd_valid), .tbl_rd_data(tbl_rd_data),
		.cfg_loaded(cfg_loaded), .code_protect_en(code_protect_en),
		.write_protect_en(write_protect_en), .two_speed_startup(two_speed_startup),
		.pwm_key_lock(pwm_key_lock), .watchdog_window_sel(watchdog_window_sel),
		.initial_osc_sel(initial_osc_sel), .clock_switch_monitor_mode(clock_switch_monitor_mode),
		.pin_remap_once(pin_remap_once), .osc2_pin_function(osc2_pin_function),
		.primary_osc_mode(primary_osc_mode), .watchdog_force_enable(watchdog_force_enable),
		.watchdog_window_disable(watchdog_window_disable), .pll_lock_wait(pll_lock_wait),
		.watchdog_prescale_sel(watchdog_prescale_sel),
		.watchdog_postscale_sel(watchdog_postscale_sel), .pwm_pin_owner(pwm_pin_owner),
		.high_side_polarity(high_side_polarity), .low_side_polarity(low_side_polarity),
		.alt_i2c_pins(alt_i2c_pins), .debug_channel_sel(debug_channel_sel));
	csl_flash_model flash (.ref_clk(ref_clk), .flash_rd_req(flash_rd_req),
		.flash_rd_addr(flash_rd_addr), .flash_rd_valid(flash_rd_valid),
		.flash_rd_data(flash_rd_data), .word_a(word_a), .word_b(word_b), .lat(lat));
	// Sampled mid-cycle, where the request has settled
	always @(negedge ref_clk) if (flash_rd_req === 1'b1) addrs.push_back(flash_rd_addr);
	function automatic logic [47:0] exp_regs(input logic [23:0] a, input logic [23:0] b);
		exp_regs = {6'h3F, a[13], a[12], b[15], b[14], 1'h1, b[12:11], b[10:8],
			b[7:6], b[4], 2'h3, b[5], b[1:0], a[7:0], b[13], a[10], b[3], b[2], 4'hF,
			a[11], 1'h1, a[15:14], 2'h3, a[9:8]};
	endfunction
	task automatic tbl_read(input logic [23:0] addr, input bit ev, input logic [7:0] exp);
		@(negedge ref_clk);
		tbl_rd_en = 1'b1;
		tbl_addr = addr;
		@(negedge ref_clk);
		tbl_rd_en = 1'b0;
		`CHK(tbl_rd_valid, ev)
		if (ev) `CHK(tbl_rd_data, exp)
	endtask
	task automatic tbl_write(input logic [23:0] addr, input logic [7:0] d);
		@(negedge ref_clk);
		tbl_wr_en = 1'b1;
		tbl_addr = addr;
		tbl_wr_data = d;
		@(negedge ref_clk);
		tbl_wr_en = 1'b0;
	endtask
	task automatic load_check(input logic [23:0] a, b, input logic [3:0] l, input string name);
		logic [47:0] e;
		int n;
		logic [14:0] fld;
		e = exp_regs(a, b);
		@(negedge ref_clk);
		word_a = a;
		word_b = b;
		lat = l;
		sys_rst = 1'b1;
		repeat (5) @(negedge ref_clk);
		sys_rst = 1'b0;
		tbl_read(csl_pkg::OFS_SEGMENT_PROTECT, 1'b1, 8'hFF);
		n = 0;
		while (cfg_loaded !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(cfg_loaded, 1'b1)
		`CHK(addrs[$-1], csl_pkg::LARGE_WORD_B_ADDR)
		`CHK(addrs[$], csl_pkg::LARGE_WORD_A_ADDR)
		for (int i = 0; i < 6; i++) begin
			tbl_read(csl_pkg::OFS_SEGMENT_PROTECT + 24'(2 * i), 1'b1, e[47 - 8 * i -: 8]);
		end
		`CHK(code_protect_en, ~a[13])
		`CHK(write_protect_en, ~a[12])
		`CHK({initial_osc_sel, watchdog_postscale_sel}, {b[10:8], a[3:0]})
		`CHK({debug_channel_sel, high_side_polarity, primary_osc_mode}, {a[9:8], a[10], b[1:0]})
		fld = {two_speed_startup, pwm_key_lock, watchdog_window_sel, clock_switch_monitor_mode,
			pin_remap_once, osc2_pin_function, watchdog_force_enable, watchdog_window_disable,
			pll_lock_wait, watchdog_prescale_sel, pwm_pin_owner, low_side_polarity, alt_i2c_pins};
		`CHK(fld[14:7], {b[15], b[14], b[12:11], b[7:6], b[4], b[5]})
		`CHK(fld[6:0], {a[7:4], b[13], b[3], b[2]})
		$display("test %0s done", name);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		failures++;
		print_verdict();
	end
	initial begin
		// Upper byte all ones, tool bit set, reserved debug bits clear
		load_check(24'hFF2B5C, 24'hFFA5C6, 4'h8, "slow_load");
		tbl_read(24'hF80000, 1'b1, 8'hFF);
		tbl_read(24'hF80005, 1'b1, 8'hFF);
		tbl_read(24'hF80010, 1'b1, 8'hFF);
		tbl_write(csl_pkg::OFS_SEGMENT_PROTECT, 8'h00);
		tbl_read(csl_pkg::OFS_SEGMENT_PROTECT, 1'b1, 8'hFE);
		tbl_read(24'h7FFFFE, 1'b0, 8'hFF);
		$display("test access_rules done");
		// Upper byte zero must change nothing
		load_check(24'h001A93, 24'h005A39, 4'h1, "fast_reload");
		load_check(24'h000000, 24'h000000, 4'h3, "erased_page");
		print_verdict();
	end
endmodule
`default_nettype wire

//--- tb/csl_flash_model.sv
// Purpose: Behavioural flash holding the two configuration words.
// Assumes: Word A sits at the odd-word address (bit 1 set), word B below it.
// Notes: Latency is set by the bench; data toggles whenever not valid.
`timescale 1ns/10ps
`default_nettype none
module csl_flash_model (
	// Clock
	input wire logic ref_clk,
	// Read port
	input wire logic flash_rd_req,
	input wire logic [23:0] flash_rd_addr,
	output logic flash_rd_valid,
	output logic [23:0] flash_rd_data,
	// Contents and timing
	input wire logic [23:0] word_a,
	input wire logic [23:0] word_b,
	input wire logic [3:0] lat
);
	logic busy;
	logic [3:0] cnt;
	logic [23:0] addr_q;
	initial begin
		busy = 1'b0;
		cnt = 4'h0;
		addr_q = 24'h000000;
		flash_rd_valid = 1'b0;
		flash_rd_data = 24'h000000;
	end
	always @(posedge ref_clk) begin
		flash_rd_valid <= 1'b0;
		// Stale data must not look like a held answer
		flash_rd_data <= ~flash_rd_data;
		if (flash_rd_req) begin
			busy <= 1'b1;
			cnt <= lat;
			addr_q <= flash_rd_addr;
		end else if (busy && cnt <= 4'h1) begin
			busy <= 1'b0;
			flash_rd_valid <= 1'b1;
			flash_rd_data <= addr_q[1] ? word_a : word_b;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire
